// file: verif/par_ram_model.sv
// RAM model holding the received packet, the key table and the scratch area
`default_nettype none

module par_ram_model
  import par_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // RAM slave side
  input wire par_mem_req_t MEM_REQ,
  output var par_mem_rsp_t MEM_RSP,
  // Wait cycles before each answer
  input wire logic [7:0] DELAY
);
  logic [31:0] mem [0:255];
  logic [7:0] wait_reg;

  // Read data is inverted every cycle it is not loaded, so a sample one cycle late never looks valid
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_reg <= 8'h00;
      MEM_RSP <= '0;
    end else begin
      MEM_RSP.ack <= 1'b0;
      MEM_RSP.rdata <= ~MEM_RSP.rdata;
      if (MEM_REQ.req && !MEM_RSP.ack) begin
        if (wait_reg >= DELAY) begin
          wait_reg <= 8'h00;
          MEM_RSP.ack <= 1'b1;
          if (MEM_REQ.we) begin
            mem[MEM_REQ.addr[9:2]] <= MEM_REQ.wdata;
          end else begin
            MEM_RSP.rdata <= mem[MEM_REQ.addr[9:2]];
          end
        end else begin
          wait_reg <= wait_reg + 8'h01;
        end
      end
    end
  end
endmodule : par_ram_model

`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the private address resolver
`default_nettype none

module tb_top
  import par_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  par_apb_req_t apb_req = '0;
  par_apb_rsp_t apb_rsp;
  par_mem_req_t mem_req;
  par_mem_rsp_t mem_rsp;
  logic [255:0] chan_in = '0;
  logic [255:0] chan_out;
  logic [7:0] ram_delay = 8'h00;
  logic [31:0] last_rd = 32'h00000000;
  logic pub_seen = 1'b0;
  int nrd = 0;
  int rd_base = 0;
  int mismatches = 0;
  int check_count = 0;

  par_resolver par_resolver_inst (.CLK(CLK), .RST_B(RST_B), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
    .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .CHAN_IN(chan_in), .CHAN_OUT(chan_out));
  par_ram_model par_ram_model_inst (.CLK(CLK), .RST_B(RST_B), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp),
    .DELAY(ram_delay));

  initial begin
    forever #20 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (mem_req.req && mem_rsp.ack && !mem_req.we) begin
      nrd <= nrd + 1;
      last_rd <= mem_req.addr;
    end
    if (chan_out[5] === 1'b1) begin
      pub_seen <= 1'b1;
    end
  end

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge CLK);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge CLK);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge CLK);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q, exp);
  endtask : rdc

  task automatic clear_and_run(input logic [31:0] keys);
    logic [31:0] q;
    logic e;
    int n;
    wr(PAR_OFF_EV_DONE, 32'h00000000);
    wr(PAR_OFF_EV_MATCH, 32'h00000000);
    wr(PAR_OFF_EV_NOMATCH, 32'h00000000);
    wr(PAR_OFF_KEY_COUNT, keys);
    rd_base = nrd;
    wr(PAR_OFF_START, 32'h00000001);
    n = 0;
    do begin
      apb(1'b0, PAR_OFF_EV_DONE, 32'h00000000, q, e);
      n++;
    end while (q[0] !== 1'b1 && n < 400);
    chk({31'h0, q[0]}, 32'h00000001);
  endtask : clear_and_run

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rdc(PAR_OFF_STATUS, 32'h00000000);
    rdc(PAR_OFF_ENABLE, 32'h00000000);
    apb(1'b0, PAR_OFF_NONE, 32'h00000000, q, e);
    chk({31'h0, e}, 32'h00000001);
    $display("reset test done");
  endtask : t_reset

  // Keys 0 and 1 are scrambled, key 2 is the all-zero key that resolves the packet
  task automatic t_match();
    wr(PAR_OFF_ENABLE, 32'h00000003);
    wr(PAR_OFF_KEY_PTR, 32'h00000040);
    wr(PAR_OFF_ADDR_PTR, 32'h00000000);
    wr(PAR_OFF_SCR_PTR, 32'h00000200);
    wr(PAR_OFF_PUB_MATCH, 32'h80000005);
    clear_and_run(32'h00000004);
    chk({31'h0, mem_req.req}, 32'h00000000);
    rdc(PAR_OFF_EV_MATCH, 32'h00000001);
    rdc(PAR_OFF_EV_NOMATCH, 32'h00000000);
    rdc(PAR_OFF_STATUS, 32'h00000002);
    chk(nrd - rd_base, 32'd14);
    chk(last_rd, 32'h0000006C);
    chk(par_ram_model_inst.mem[128], 32'hCA342B2E);
    chk({31'h0, pub_seen}, 32'h00000001);
    $display("match test done");
  endtask : t_match

  task automatic t_nomatch();
    clear_and_run(32'h00000002);
    rdc(PAR_OFF_EV_NOMATCH, 32'h00000001);
    rdc(PAR_OFF_EV_MATCH, 32'h00000000);
    chk(nrd - rd_base, 32'd10);
    clear_and_run(32'h00000000);
    rdc(PAR_OFF_EV_NOMATCH, 32'h00000001);
    chk(nrd - rd_base, 32'd0);
    $display("no-match test done");
  endtask : t_nomatch

  task automatic t_stop();
    wr(PAR_OFF_EV_DONE, 32'h00000000);
    wr(PAR_OFF_KEY_COUNT, 32'h00000004);
    ram_delay <= 8'h14;
    wr(PAR_OFF_SUB_START, 32'h80000007);
    chan_in[7] <= 1'b1;
    @(posedge CLK);
    chan_in <= '0;
    repeat (4) @(posedge CLK);
    rdc(PAR_OFF_STATUS, 32'h00000102);
    wr(PAR_OFF_STOP, 32'h00000001);
    repeat (60) @(posedge CLK);
    rdc(PAR_OFF_EV_DONE, 32'h00000000);
    rdc(PAR_OFF_STATUS, 32'h00000002);
    ram_delay <= 8'h00;
    wr(PAR_OFF_ENABLE, 32'h00000000);
    wr(PAR_OFF_START, 32'h00000001);
    repeat (60) @(posedge CLK);
    rdc(PAR_OFF_EV_DONE, 32'h00000000);
    // Subscribed stop lands while the cipher runs, with no RAM request open
    wr(PAR_OFF_ENABLE, 32'h00000003);
    wr(PAR_OFF_SUB_STOP, 32'h80000009);
    wr(PAR_OFF_START, 32'h00000001);
    repeat (14) @(posedge CLK);
    chan_in[9] <= 1'b1;
    @(posedge CLK);
    chan_in <= '0;
    repeat (40) @(posedge CLK);
    rdc(PAR_OFF_EV_DONE, 32'h00000000);
    rdc(PAR_OFF_STATUS, 32'h00000002);
    wr(PAR_OFF_INTSET, 32'h00000007);
    wr(PAR_OFF_INTCLR, 32'h00000002);
    rdc(PAR_OFF_INTSET, 32'h00000005);
    $display("stop test done");
  endtask : t_stop

  initial begin
    for (int i = 0; i < 256; i++) begin
      par_ram_model_inst.mem[i] = (i >= 16 && i < 24) ? (32'hA5A5A5A5 ^ i) : 32'h00000000;
    end
    par_ram_model_inst.mem[0] = 32'h00342B2E;
    par_ram_model_inst.mem[128] = 32'h5A5A5A5A;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_match();
    t_nomatch();
    t_stop();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    complete_run();
  end
endmodule : tb_top

`default_nettype wire

// file: verilog/par_pkg.sv
// Constants, carriers and state layout of the private address resolver
// How it works
// R1: Software points the address pointer at the received packet before starting.
// R2: The received address is six bytes read from the address pointer.
// R3: Writing 1 to the start trigger begins a run over the key table.
// R4: A match event is raised when any key resolves the address.
// R5: Keys are tried in ascending order from index zero up to fifteen.
// R6: The key count sets how many keys, from index zero, are tried.
// R7: A no-match event is raised when no configured key resolves the address.
// R8: Each key in turn gets the private address hash check.
// R9: The address type is never examined or filtered.
// R10: The run halts at the first matching key or after all configured keys.
// R11: A completion event follows every halted run, matched or not; a run aborted by stop or by disabling raises no completion event.
// R12: Latency depends on the matching key position and on RAM contention.
// R13: The controller may start once six packet bytes are in RAM.
// R14: The key table is fetched from the key table pointer.
// R15: Key n sits 16 times n bytes from the table base.
// R16: The stop trigger, by write or subscription, aborts a run.
// R17: Subscription registers hold a channel index and enable bit.
// R18: The scratch pointer area receives intermediate data during a run.
// R19: All RAM accesses are finished before any result event.
// R20: Event flags read 1 after their event, cleared by writing 0.
// R21: Writing 1 to an interrupt enable clear bit disables that event.
// R22: Encrypt padded upper address bytes; low 24 result bits must equal lower bytes.
// R23: Nothing runs unless the enable register selects the enabled state.
`default_nettype none

package par_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] PAR_OFF_START = 12'h000;
  localparam logic [11:0] PAR_OFF_STOP = 12'h008;
  localparam logic [11:0] PAR_OFF_SUB_START = 12'h080;
  localparam logic [11:0] PAR_OFF_SUB_STOP = 12'h088;
  localparam logic [11:0] PAR_OFF_EV_DONE = 12'h100;
  localparam logic [11:0] PAR_OFF_EV_MATCH = 12'h104;
  localparam logic [11:0] PAR_OFF_EV_NOMATCH = 12'h108;
  localparam logic [11:0] PAR_OFF_PUB_DONE = 12'h180;
  localparam logic [11:0] PAR_OFF_PUB_MATCH = 12'h184;
  localparam logic [11:0] PAR_OFF_PUB_NOMATCH = 12'h188;
  localparam logic [11:0] PAR_OFF_INTSET = 12'h304;
  localparam logic [11:0] PAR_OFF_INTCLR = 12'h308;
  localparam logic [11:0] PAR_OFF_STATUS = 12'h400;
  localparam logic [11:0] PAR_OFF_ENABLE = 12'h500;
  localparam logic [11:0] PAR_OFF_KEY_COUNT = 12'h504;
  localparam logic [11:0] PAR_OFF_KEY_PTR = 12'h508;
  localparam logic [11:0] PAR_OFF_ADDR_PTR = 12'h510;
  localparam logic [11:0] PAR_OFF_SCR_PTR = 12'h514;
  localparam logic [11:0] PAR_OFF_NONE = 12'hFFF;

  // ----------------------------------------
  // Fields, codes and counts
  // ----------------------------------------
  localparam int PAR_CFG_EN_BIT = 31;
  localparam int PAR_STATUS_BUSY_BIT = 8;
  localparam logic [1:0] PAR_ENABLE_ON = 2'h3;
  localparam logic [4:0] PAR_MAX_KEYS = 5'h10;
  localparam logic [1:0] PAR_ADDR_LAST_WORD = 2'h1;
  localparam logic [1:0] PAR_KEY_LAST_WORD = 2'h3;
  localparam logic [3:0] PAR_LAST_ROUND = 4'hA;
  localparam logic [7:0] PAR_RCON_FIRST = 8'h01;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RDADDR = 7'h02,
    ST_RDKEY = 7'h04,
    ST_CIPHER = 7'h08,
    ST_WRSCR = 7'h10,
    ST_CHECK = 7'h20,
    ST_FINISH = 7'h40
  } par_fsm_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } par_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } par_apb_rsp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } par_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } par_mem_rsp_t;

  typedef struct packed {
    logic en;
    logic [7:0] ch;
  } par_chan_cfg_t;

  typedef struct packed {
    par_fsm_t fsm;
    par_apb_rsp_t rsp;
    par_mem_req_t mem;
    par_chan_cfg_t sub_start;
    par_chan_cfg_t sub_stop;
    par_chan_cfg_t pub_done;
    par_chan_cfg_t pub_match;
    par_chan_cfg_t pub_nomatch;
    logic ev_done;
    logic ev_match;
    logic ev_nomatch;
    logic [2:0] inten;
    logic [1:0] enable;
    logic [4:0] key_count;
    logic [31:0] key_ptr;
    logic [31:0] addr_ptr;
    logic [31:0] scr_ptr;
    logic [3:0] status_idx;
    logic [3:0] key_idx;
    logic [1:0] word;
    logic abort;
    logic found;
    logic [47:0] addr_bytes;
    logic [127:0] key;
    logic [127:0] aes;
    logic [127:0] rk;
    logic [7:0] rcon;
    logic [3:0] round;
    logic [255:0] pub;
  } par_state_t;
endpackage : par_pkg

`default_nettype wire

// file: verilog/par_resolver.sv
// Private address resolver: APB registers, RAM master and iterative block cipher
`default_nettype none

module par_resolver
  import par_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // APB register slave
  input wire par_apb_req_t APB_REQ,
  output var par_apb_rsp_t APB_RSP,
  // RAM master
  output var par_mem_req_t MEM_REQ,
  input wire par_mem_rsp_t MEM_RSP,
  // Event channel fabric
  input wire logic [255:0] CHAN_IN,
  output var logic [255:0] CHAN_OUT
);

  // ----------------------------------------
  // Cipher arithmetic
  // ----------------------------------------
  function automatic logic [7:0] par_xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction : par_xt

  function automatic logic [7:0] par_gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = par_xt(x);
    end
    return p;
  endfunction : par_gmul

  // Inverse by exponent 254 saves a 256-entry table at the cost of logic depth
  function automatic logic [7:0] par_sbox(input logic [7:0] a);
    logic [7:0] r;
    r = a;
    for (int i = 0; i < 6; i++) begin
      r = par_gmul(par_gmul(r, r), a);
    end
    r = par_gmul(r, r);
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
  endfunction : par_sbox

  function automatic logic [127:0] par_kexp(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w [4];
    logic [31:0] g;
    for (int i = 0; i < 4; i++) begin
      w[i] = k[127-32*i -: 32];
    end
    g = {par_sbox(w[3][23:16]) ^ rc, par_sbox(w[3][15:8]), par_sbox(w[3][7:0]), par_sbox(w[3][31:24])};
    w[0] = w[0] ^ g;
    w[1] = w[1] ^ w[0];
    w[2] = w[2] ^ w[1];
    w[3] = w[3] ^ w[2];
    return {w[0], w[1], w[2], w[3]};
  endfunction : par_kexp

  function automatic logic [127:0] par_round(input logic [127:0] s, input logic [127:0] k, input logic last);
    logic [7:0] b [16];
    logic [7:0] t [16];
    logic [127:0] o;
    for (int i = 0; i < 16; i++) begin
      b[i] = par_sbox(s[127-8*i -: 8]);
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[r+4*c] = b[r+4*((c+r)%4)];
      end
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (last) begin
          o[127-8*(r+4*c) -: 8] = t[r+4*c];
        end else begin
          o[127-8*(r+4*c) -: 8] = par_xt(t[4*c+r]) ^ par_xt(t[4*c+(r+1)%4]) ^ t[4*c+(r+1)%4]
                                  ^ t[4*c+(r+2)%4] ^ t[4*c+(r+3)%4];
        end
      end
    end
    return o ^ k;
  endfunction : par_round

  // RAM words are little endian; the cipher wants the lowest byte first
  function automatic logic [31:0] par_bswap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : par_bswap

  function automatic logic [31:0] par_cfg_rd(input par_chan_cfg_t c);
    logic [31:0] v;
    v = 32'h00000000;
    v[PAR_CFG_EN_BIT] = c.en;
    v[7:0] = c.ch;
    return v;
  endfunction : par_cfg_rd

  function automatic par_chan_cfg_t par_cfg_wr(input logic [31:0] d);
    return {d[PAR_CFG_EN_BIT], d[7:0]};
  endfunction : par_cfg_wr

  // ----------------------------------------
  // State
  // ----------------------------------------
  par_state_t r;
  par_state_t n;

  logic setup;
  logic [11:0] wa;
  logic [31:0] wd;
  logic hit;
  logic [31:0] rdata;
  logic enabled;
  logic busy;
  logic start_trig;
  logic stop_trig;
  logic halt;
  logic mem_done;
  logic [4:0] cnt;
  logic [127:0] key_full;
  logic [127:0] rk_next;
  logic [127:0] aes_next;
  logic set_done;
  logic set_match;
  logic set_nomatch;
  logic in_cipher;
  logic in_rdkey;

  assign APB_RSP = r.rsp;
  assign MEM_REQ = r.mem;
  assign CHAN_OUT = r.pub;

  always_comb begin
    n = r;
    // Register bus: answer is prepared in setup, write lands at the access edge
    setup = APB_REQ.psel && !APB_REQ.penable;
    wa = (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && r.rsp.pready) ? APB_REQ.paddr : PAR_OFF_NONE;
    wd = APB_REQ.pwdata;
    enabled = (r.enable == PAR_ENABLE_ON);
    busy = (r.fsm != ST_IDLE);
    cnt = (r.key_count > PAR_MAX_KEYS) ? PAR_MAX_KEYS : r.key_count;
    start_trig = ((wa == PAR_OFF_START) && wd[0]) || (r.sub_start.en && CHAN_IN[r.sub_start.ch]); // see R3 see R17
    stop_trig = ((wa == PAR_OFF_STOP) && wd[0]) || (r.sub_stop.en && CHAN_IN[r.sub_stop.ch]); // see R16 see R17
    mem_done = r.mem.req && MEM_RSP.ack;
    halt = busy && (stop_trig || !enabled || r.abort);
    key_full = {r.key[127:32], par_bswap(MEM_RSP.rdata)};
    rk_next = par_kexp(r.rk, r.rcon);
    aes_next = par_round(r.aes, rk_next, r.round == PAR_LAST_ROUND);
    set_done = (r.fsm == ST_FINISH) && !halt;
    set_match = set_done && r.found;
    set_nomatch = set_done && !r.found;
    in_cipher = (r.fsm == ST_CIPHER);
    in_rdkey = (r.fsm == ST_RDKEY);

    hit = 1'b1;
    case (APB_REQ.paddr)
      PAR_OFF_START, PAR_OFF_STOP: rdata = 32'h00000000;
      PAR_OFF_SUB_START: rdata = par_cfg_rd(r.sub_start);
      PAR_OFF_SUB_STOP: rdata = par_cfg_rd(r.sub_stop);
      PAR_OFF_EV_DONE: rdata = {31'h00000000, r.ev_done};
      PAR_OFF_EV_MATCH: rdata = {31'h00000000, r.ev_match};
      PAR_OFF_EV_NOMATCH: rdata = {31'h00000000, r.ev_nomatch};
      PAR_OFF_PUB_DONE: rdata = par_cfg_rd(r.pub_done);
      PAR_OFF_PUB_MATCH: rdata = par_cfg_rd(r.pub_match);
      PAR_OFF_PUB_NOMATCH: rdata = par_cfg_rd(r.pub_nomatch);
      PAR_OFF_INTSET, PAR_OFF_INTCLR: rdata = {29'h00000000, r.inten};
      PAR_OFF_STATUS: begin
        rdata = {28'h0000000, r.status_idx};
        rdata[PAR_STATUS_BUSY_BIT] = busy;
      end
      PAR_OFF_ENABLE: rdata = {30'h00000000, r.enable};
      PAR_OFF_KEY_COUNT: rdata = {27'h0000000, r.key_count};
      PAR_OFF_KEY_PTR: rdata = r.key_ptr;
      PAR_OFF_ADDR_PTR: rdata = r.addr_ptr;
      PAR_OFF_SCR_PTR: rdata = r.scr_ptr;
      default: begin
        rdata = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    n.rsp.pready = setup;
    if (setup) begin
      n.rsp.pslverr = !hit;
      n.rsp.prdata = rdata;
    end

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    if (wa == PAR_OFF_SUB_START) begin
      n.sub_start = par_cfg_wr(wd);
    end
    if (wa == PAR_OFF_SUB_STOP) begin
      n.sub_stop = par_cfg_wr(wd);
    end
    if (wa == PAR_OFF_PUB_DONE) begin
      n.pub_done = par_cfg_wr(wd);
    end
    if (wa == PAR_OFF_PUB_MATCH) begin
      n.pub_match = par_cfg_wr(wd);
    end
    if (wa == PAR_OFF_PUB_NOMATCH) begin
      n.pub_nomatch = par_cfg_wr(wd);
    end
    if (wa == PAR_OFF_ENABLE) begin
      n.enable = wd[1:0];
    end
    if (wa == PAR_OFF_KEY_COUNT) begin
      n.key_count = wd[4:0];
    end
    if (wa == PAR_OFF_KEY_PTR) begin
      n.key_ptr = wd;
    end
    if (wa == PAR_OFF_ADDR_PTR) begin
      n.addr_ptr = wd;
    end
    if (wa == PAR_OFF_SCR_PTR) begin
      n.scr_ptr = wd;
    end
    n.inten = (r.inten | ((wa == PAR_OFF_INTSET) ? wd[2:0] : 3'h0))
              & ~((wa == PAR_OFF_INTCLR) ? wd[2:0] : 3'h0); // see R21

    // Hardware set wins over a software write in the same cycle
    n.ev_done = set_done | ((wa == PAR_OFF_EV_DONE) ? wd[0] : r.ev_done); // see R20 see R11
    n.ev_match = set_match | ((wa == PAR_OFF_EV_MATCH) ? wd[0] : r.ev_match); // see R20 see R4
    n.ev_nomatch = set_nomatch | ((wa == PAR_OFF_EV_NOMATCH) ? wd[0] : r.ev_nomatch); // see R20 see R7
    n.pub = '0;
    if (set_done && r.pub_done.en) begin
      n.pub[r.pub_done.ch] = 1'b1;
    end
    if (set_match && r.pub_match.en) begin
      n.pub[r.pub_match.ch] = 1'b1;
    end
    if (set_nomatch && r.pub_nomatch.en) begin
      n.pub[r.pub_nomatch.ch] = 1'b1;
    end

    // ----------------------------------------
    // Resolution sequencer
    // ----------------------------------------
    if (halt) begin
      // An outstanding RAM request is carried to its answer before giving up the bus
      if (r.mem.req && !MEM_RSP.ack) begin
        n.abort = 1'b1; // see R16
      end else begin
        n.fsm = ST_IDLE; // see R16 see R23
        n.mem.req = 1'b0;
        n.abort = 1'b0;
      end
    end else begin
      case (r.fsm)
        ST_IDLE: begin
          if (start_trig && enabled) begin // see R3 see R23
            n.key_idx = 4'h0; // see R5
            n.word = 2'h0;
            n.found = 1'b0;
            if (cnt == 5'h00) begin
              n.fsm = ST_FINISH; // see R6
            end else begin
              n.fsm = ST_RDADDR;
              n.mem = '{req: 1'b1, we: 1'b0, addr: r.addr_ptr, wdata: 32'h00000000}; // see R1 see R2
            end
          end
        end
        ST_RDADDR: begin
          // Wait here for as long as the RAM arbiter withholds the answer
          if (mem_done) begin // see R12
            n.mem.addr = r.mem.addr + 32'h00000004;
            n.word = r.word + 2'h1;
            if (r.word == PAR_ADDR_LAST_WORD) begin
              n.addr_bytes[47:32] = MEM_RSP.rdata[15:0]; // see R2
              n.word = 2'h0;
              n.fsm = ST_RDKEY;
              n.mem.addr = r.key_ptr; // see R14 see R15
            end else begin
              n.addr_bytes[31:0] = MEM_RSP.rdata;
            end
          end
        end
        ST_RDKEY: begin
          if (mem_done) begin
            n.key[127-32*r.word -: 32] = par_bswap(MEM_RSP.rdata);
            n.mem.addr = r.mem.addr + 32'h00000004;
            n.word = r.word + 2'h1;
            if (r.word == PAR_KEY_LAST_WORD) begin
              // The type bits in the top byte are used as received, never filtered
              n.mem.req = 1'b0;
              n.aes = {104'h0, r.addr_bytes[47:24]} ^ key_full; // see R9 see R22
              n.rk = key_full;
              n.rcon = PAR_RCON_FIRST;
              n.round = 4'h1;
              n.fsm = ST_CIPHER; // see R8
            end
          end
        end
        ST_CIPHER: begin
          n.aes = aes_next; // see R22
          n.rk = rk_next;
          n.rcon = par_xt(r.rcon);
          n.round = r.round + 4'h1;
          if (r.round == PAR_LAST_ROUND) begin
            n.fsm = ST_WRSCR;
            n.mem = '{req: 1'b1, we: 1'b1, addr: r.scr_ptr, wdata: aes_next[31:0]}; // see R18
          end
        end
        ST_WRSCR: begin
          if (mem_done) begin
            n.mem.req = 1'b0;
            n.mem.we = 1'b0;
            n.fsm = ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (r.aes[23:0] == r.addr_bytes[23:0]) begin // see R22
            n.found = 1'b1;
            n.status_idx = r.key_idx;
            n.fsm = ST_FINISH; // see R10
          end else if ({1'b0, r.key_idx} + 5'h01 == cnt) begin
            n.fsm = ST_FINISH; // see R10 see R7
          end else begin
            n.key_idx = r.key_idx + 4'h1; // see R5
            n.word = 2'h0;
            n.fsm = ST_RDKEY;
            n.mem = '{req: 1'b1, we: 1'b0, addr: r.key_ptr + {24'h000000, r.key_idx + 4'h1, 4'h0},
                      wdata: 32'h00000000}; // see R15
          end
        end
        ST_FINISH: begin
          n.fsm = ST_IDLE; // see R11 see R19
        end
        default: begin
          n.fsm = ST_IDLE;
          n.mem.req = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
      r.fsm <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_START_RUNS: assert property (!busy && start_trig && enabled |=> busy) // see R3
    else $error("start trigger did not begin a run");
  AST_ENABLE_GATES: assert property ($rose(busy) |-> $past(enabled)) // see R23
    else $error("run began while unit disabled");
  AST_ADDR_FETCH: assert property ((r.fsm == ST_RDADDR) && r.mem.req
      |-> !r.mem.we && (r.mem.addr == r.addr_ptr + {28'h0000000, r.word, 2'b00})) // see R2
    else $error("address fetch at wrong location");
  AST_KEY_FETCH: assert property (in_rdkey && r.mem.req && !r.mem.we
      |-> r.mem.addr == r.key_ptr + {24'h000000, r.key_idx, 4'h0} + {28'h0000000, r.word, 2'b00}) // see R15
    else $error("key fetch at wrong location");
  AST_KEY_LIMIT: assert property (in_rdkey |-> {1'b0, r.key_idx} < cnt) // see R6
    else $error("key index beyond key count");
  AST_CIPHER_SPAN: assert property ($rose(r.fsm == ST_WRSCR) |-> $past(in_cipher, 10) && $past(in_rdkey, 11)) // see R8
    else $error("cipher did not take ten rounds");
  AST_MATCH_HALTS: assert property ((r.fsm == ST_CHECK) && !halt && (r.aes[23:0] == r.addr_bytes[23:0])
      |=> (r.fsm == ST_FINISH) && r.found && (r.status_idx == $past(r.key_idx))) // see R10
    else $error("match did not halt the run");
  AST_BUS_QUIET: assert property (set_done |-> !r.mem.req) // see R19
    else $error("result event with RAM access open");
  AST_ONE_RESULT: assert property (set_done |-> set_match ^ set_nomatch) // see R11
    else $error("completion without exactly one result");
  AST_FLAG_SET: assert property (set_match |=> r.ev_match ##1 r.ev_match || $past(wa == PAR_OFF_EV_MATCH)) // see R20
    else $error("match flag not held");
  AST_NOMATCH_FLAG: assert property (set_nomatch |=> r.ev_nomatch && r.fsm == ST_IDLE) // see R7
    else $error("no-match flag not set");
  AST_STOP_ABORT: assert property (busy && stop_trig && !r.mem.req // see R16
      |=> !busy && (!$rose(r.ev_done) || $past(wa == PAR_OFF_EV_DONE)))
    else $error("stop did not abort");
  AST_INTEN_CLR: assert property ((wa == PAR_OFF_INTCLR) && wd[1] |=> !r.inten[1]) // see R21
    else $error("interrupt enable not cleared");
  AST_SUB_START: assert property (!busy && enabled && r.sub_start.en && CHAN_IN[r.sub_start.ch]
      |=> busy) // see R17
    else $error("subscribed start ignored");
  AST_SCRATCH: assert property ((r.fsm == ST_WRSCR) && r.mem.req |-> r.mem.we && r.mem.addr == r.scr_ptr) // see R18
    else $error("scratch write at wrong location");
  AST_FIRST_KEY: assert property ($rose(in_rdkey) && $past(r.fsm == ST_RDADDR) |-> r.key_idx == 4'h0) // see R5
    else $error("run did not start at key zero");

endmodule : par_resolver

`default_nettype wire

// file: verilog/par_resolver_unused_guard.sv
// Spare design source: holds no logic of its own
`default_nettype none
`default_nettype wire
